// *** rtl/secondary_fault_status_word.sv ***
// read-only secondary-side fault status word with detector synchronisation
//
// Summary of operation
// - bit 15 gives gate level: low-side pin when high side driven, else high-side pin.
// - bit 14 sets when sensed gate level disagrees with expected output.
// - bit 12 sets on any secondary internal rail over or undervoltage.
// - bit 11 reads 1 while the Miller clamp is engaged, else 0.
// - bit 10 flags negative supply overvoltage, only when its monitor is enabled.
// - bit 9 flags negative supply undervoltage, only when its monitor is enabled.
// - bit 8 flags positive supply overvoltage unless that monitor is disabled.
// - bit 7 flags positive supply undervoltage unless that monitor is disabled.
// - bit 6 flags collector-emitter clamp soft turn-off when clamp is enabled.
// - bit 5 sets when any enabled temperature input exceeds its threshold.
// - bit 3 sets while the regulator current limit is active.
// - bit 2 sets when any enabled current input exceeds short-circuit threshold.
// - bit 1 sets when any enabled current input exceeds overcurrent threshold.
// - bit 0 sets when desaturation sense exceeds its threshold.
// - bit 4 always reads 0; whole word read-only, resets to 0.
`timescale 1ns/1ps
module secondary_fault_status_word
  import fault_status_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // gate monitor
  input  wire logic              high_side_drive_high,
  input  wire logic              high_side_output,
  input  wire logic              low_side_output,
  input  wire logic              clamp_engaged,
  // supply and regulator detectors
  input  wire logic              secondary_regulator_fault,
  input  wire logic              secondary_rail_event,
  input  wire logic              neg_supply_over,
  input  wire logic              neg_supply_under,
  input  wire logic              pos_supply_over,
  input  wire logic              pos_supply_under,
  input  wire logic              regulator_current_limit,
  // transistor protection detectors
  input  wire logic              ce_clamp_turnoff,
  input  wire logic [AI_N-1:0]   temp_over_threshold,
  input  wire logic [AI_N-1:0]   current_over_short,
  input  wire logic [AI_N-1:0]   current_over_limit,
  input  wire logic              collector_saturation_sense,
  // configuration settings
  input  wire logic              neg_supply_monitor_enable,
  input  wire logic              pos_over_monitor_disable,
  input  wire logic              pos_under_monitor_disable,
  input  wire logic              ce_clamp_enable,
  input  wire logic [AI_N-1:0]   temp_input_enable,
  input  wire logic [AI_N-1:0]   current_input_enable,
  // register read side
  input  wire logic              status_clear,
  output logic [WORD_W-1:0]      secondary_fault_status_three
);

  // ----------------------------------------------------------------------
  // detector synchronisation
  // ----------------------------------------------------------------------
  detector_if det ();

  // pack raw detector lines in the shared layout
  assign det.raw = {collector_saturation_sense, regulator_current_limit, current_over_limit,
                    current_over_short, temp_over_threshold, ce_clamp_turnoff, pos_supply_under,
                    pos_supply_over, neg_supply_under, neg_supply_over, secondary_rail_event,
                    secondary_regulator_fault, clamp_engaged, low_side_output, high_side_output,
                    high_side_drive_high};

  detector_sync u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .det     (det)
  );

  // ----------------------------------------------------------------------
  // word state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] word;
  } word_s;

  word_s            st_r;
  word_s            st_nxt;
  logic [DET_W-1:0] s;
  logic             gate_now;
  logic [WORD_W-1:0] set_now;

  assign s        = det.synced;
  // the low-side pin carries the gate while the high side is pulled up
  assign gate_now = s[D_EXP_HIGH] ? s[D_LS_PIN] : s[D_HS_PIN];

  // fault events in word position; supply, clamp, temperature and current events gated by their settings
  always_comb begin
    set_now                  = WORD_RESET;
    set_now[B_GATE_MISMATCH] = gate_now != s[D_EXP_HIGH];
    set_now[B_REGULATOR]     = s[D_REG];
    set_now[B_RAIL_EVENT]    = s[D_RAIL];
    set_now[B_NEG_OVER]      = s[D_NEG_OV] & neg_supply_monitor_enable;
    set_now[B_NEG_UNDER]     = s[D_NEG_UV] & neg_supply_monitor_enable;
    set_now[B_POS_OVER]      = s[D_POS_OV] & ~pos_over_monitor_disable;
    set_now[B_POS_UNDER]     = s[D_POS_UV] & ~pos_under_monitor_disable;
    set_now[B_CE_CLAMP]      = s[D_CE] & ce_clamp_enable;
    set_now[B_OVERTEMP]      = |(s[D_TEMP +: AI_N] & temp_input_enable);
    set_now[B_ILIMIT]        = s[D_ILIM];
    set_now[B_SHORT]         = |(s[D_SC +: AI_N] & current_input_enable);
    set_now[B_OVERCURRENT]   = |(s[D_OC +: AI_N] & current_input_enable);
    set_now[B_SATURATION]    = s[D_SAT];
  end

  // faults are sticky until a clear; a new event in the clear cycle wins
  always_comb begin
    st_nxt                       = st_r;
    st_nxt.word                  = (st_r.word & ~{WORD_W{status_clear}}) | set_now;
    st_nxt.word[B_GATE_LEVEL]    = gate_now;
    st_nxt.word[B_CLAMP_STATE]   = s[D_CLAMP];
    st_nxt.word[B_RESERVED]      = 1'b0;
  end

  // all fields move together on one edge, so a read sees one snapshot
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{word: WORD_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign secondary_fault_status_three = st_r.word;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sat_raw_held;
    $rose(collector_saturation_sense) ##1 collector_saturation_sense ##1 collector_saturation_sense;
  endsequence

  property p_gate_level;
    1'b1 |=> st_r.word[B_GATE_LEVEL] == $past(gate_now);
  endproperty
  a_gate_level: assert property (p_gate_level) else $error("gate level bit wrong");

  property p_mismatch;
    (gate_now != s[D_EXP_HIGH]) |=> st_r.word[B_GATE_MISMATCH];
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

  property p_sticky;
    (st_r.word[B_GATE_MISMATCH] && !status_clear) |=> st_r.word[B_GATE_MISMATCH];
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag lost without clear");

  property p_rail;
    s[D_RAIL] |=> st_r.word[B_RAIL_EVENT];
  endproperty
  a_rail: assert property (p_rail) else $error("rail event not flagged");

  property p_clamp;
    1'b1 |=> st_r.word[B_CLAMP_STATE] == $past(s[D_CLAMP]);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp state wrong");

  property p_neg_gate;
    (status_clear && !neg_supply_monitor_enable) |=> !st_r.word[B_NEG_OVER] && !st_r.word[B_NEG_UNDER];
  endproperty
  a_neg_gate: assert property (p_neg_gate) else $error("negative supply flag while disabled");

  property p_neg_under;
    (s[D_NEG_UV] && neg_supply_monitor_enable) |=> st_r.word[B_NEG_UNDER];
  endproperty
  a_neg_under: assert property (p_neg_under) else $error("negative undervoltage missed");

  property p_pos_over;
    (status_clear && pos_over_monitor_disable) |=> !st_r.word[B_POS_OVER];
  endproperty
  a_pos_over: assert property (p_pos_over) else $error("positive overvoltage while disabled");

  property p_pos_under;
    (s[D_POS_UV] && !pos_under_monitor_disable) |=> st_r.word[B_POS_UNDER];
  endproperty
  a_pos_under: assert property (p_pos_under) else $error("positive undervoltage missed");

  property p_ce;
    (s[D_CE] && ce_clamp_enable) |=> st_r.word[B_CE_CLAMP];
  endproperty
  a_ce: assert property (p_ce) else $error("clamp turn-off missed");

  property p_temp;
    (|(s[D_TEMP +: AI_N] & temp_input_enable)) |=> st_r.word[B_OVERTEMP];
  endproperty
  a_temp: assert property (p_temp) else $error("overtemperature missed");

  property p_ilim;
    s[D_ILIM] |=> st_r.word[B_ILIMIT];
  endproperty
  a_ilim: assert property (p_ilim) else $error("current limit missed");

  property p_short;
    (status_clear && !(|(s[D_SC +: AI_N] & current_input_enable))) |=> !st_r.word[B_SHORT];
  endproperty
  a_short: assert property (p_short) else $error("short circuit flag not cleared");

  property p_oc;
    (|(s[D_OC +: AI_N] & current_input_enable)) |=> st_r.word[B_OVERCURRENT];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent missed");

  property p_sat_latency;
    s_sat_raw_held |=> st_r.word[B_SATURATION];
  endproperty
  a_sat_latency: assert property (p_sat_latency) else $error("saturation not seen three edges on");

  property p_reserved;
    !st_r.word[B_RESERVED];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  // only the two live bits may move on an edge with no event and no clear
  localparam logic [WORD_W-1:0] LIVE_MASK = (WORD_W'(1) << B_GATE_LEVEL) | (WORD_W'(1) << B_CLAMP_STATE);

  property p_snapshot;
    (!$past(status_clear) && $past(set_now) == '0 && $past(gate_now) == $past(s[D_EXP_HIGH]))
      |-> (st_r.word & ~LIVE_MASK) == ($past(st_r.word) & ~LIVE_MASK);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("fault bits changed with no cause");

endmodule : secondary_fault_status_word

// *** pkg/fault_status_pkg.sv ***
// constants shared by the secondary fault status word and its synchroniser
package fault_status_pkg;

  // ----------------------------------------------------------------------
  // status word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W            = 16;
  localparam logic [15:0] WORD_RESET        = 16'h0000;
  localparam int unsigned B_GATE_LEVEL      = 15;
  localparam int unsigned B_GATE_MISMATCH   = 14;
  localparam int unsigned B_REGULATOR       = 13;
  localparam int unsigned B_RAIL_EVENT      = 12;
  localparam int unsigned B_CLAMP_STATE     = 11;
  localparam int unsigned B_NEG_OVER        = 10;
  localparam int unsigned B_NEG_UNDER       = 9;
  localparam int unsigned B_POS_OVER        = 8;
  localparam int unsigned B_POS_UNDER       = 7;
  localparam int unsigned B_CE_CLAMP        = 6;
  localparam int unsigned B_OVERTEMP        = 5;
  localparam int unsigned B_RESERVED        = 4;
  localparam int unsigned B_ILIMIT          = 3;
  localparam int unsigned B_SHORT           = 2;
  localparam int unsigned B_OVERCURRENT     = 1;
  localparam int unsigned B_SATURATION      = 0;

  // ----------------------------------------------------------------------
  // detector vector layout (raw and synchronised)
  // ----------------------------------------------------------------------
  localparam int unsigned AI_N        = 3;
  localparam int unsigned D_EXP_HIGH  = 0;
  localparam int unsigned D_HS_PIN    = 1;
  localparam int unsigned D_LS_PIN    = 2;
  localparam int unsigned D_CLAMP     = 3;
  localparam int unsigned D_REG       = 4;
  localparam int unsigned D_RAIL      = 5;
  localparam int unsigned D_NEG_OV    = 6;
  localparam int unsigned D_NEG_UV    = 7;
  localparam int unsigned D_POS_OV    = 8;
  localparam int unsigned D_POS_UV    = 9;
  localparam int unsigned D_CE        = 10;
  localparam int unsigned D_TEMP      = 11;
  localparam int unsigned D_SC        = 14;
  localparam int unsigned D_OC        = 17;
  localparam int unsigned D_ILIM      = 20;
  localparam int unsigned D_SAT       = 21;
  localparam int unsigned DET_W       = 22;
  localparam logic [21:0] DET_RESET   = 22'h000000;

endpackage : fault_status_pkg

// *** pkg/detector_if.sv ***
// carrier between the status core and its detector synchroniser
`timescale 1ns/1ps
interface detector_if;
  import fault_status_pkg::*;
  logic [DET_W-1:0] raw;
  logic [DET_W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport core_side (output raw, input synced);
endinterface : detector_if

// *** rtl/detector_sync.sv ***
// two-stage synchroniser for every secondary-side detector line
`timescale 1ns/1ps
module detector_sync
  import fault_status_pkg::*;
(
  // clock and reset
  input wire logic           ref_clk,
  input wire logic           rst_n,
  // detector lines
  detector_if.sync_side      det
);

  typedef struct packed {
    logic [DET_W-1:0] stage1;
    logic [DET_W-1:0] stage2;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  // stage1 feeds only stage2, nothing else looks at it
  always_comb begin
    st_nxt        = st_r;
    st_nxt.stage1 = det.raw;
    st_nxt.stage2 = st_r.stage1;
  end

  // register the synchroniser state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{stage1: DET_RESET, stage2: DET_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign det.synced = st_r.stage2;

endmodule : detector_sync

// *** dv/host_reader.sv ***
// host-side reader that snapshots the status word and acknowledges it when rd_clear is set
`timescale 1ns/1ps
module host_reader
  import fault_status_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // read request from the bench
  input  wire logic              rd_req,
  input  wire logic              rd_clear,
  // status word and its acknowledge
  input  wire logic [WORD_W-1:0] status_word,
  output logic                   status_clear,
  // read result
  output logic                   rd_valid,
  output logic [WORD_W-1:0]      rd_data
);
  typedef struct packed {
    logic              valid;
    logic              clear;
    logic [WORD_W-1:0] data;
  } reader_s;

  reader_s st_r;
  reader_s st_nxt;

  // snapshot and acknowledge both register at the request edge; the word clears one edge later, after the read
  always_comb begin
    st_nxt       = st_r;
    st_nxt.valid = rd_req;
    st_nxt.clear = rd_req & rd_clear;
    if (rd_req) begin
      st_nxt.data = status_word;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_valid     = st_r.valid;
  assign rd_data      = st_r.data;
  assign status_clear = st_r.clear;
endmodule : host_reader

// *** dv/tb.sv ***
// self-checking bench for the secondary fault status word
`timescale 1ns/1ps
module tb;
  import fault_status_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic              ref_clk;
  logic              rst_n;
  logic [DET_W-1:0]  det;
  logic [9:0]        en;
  logic              rd_req;
  logic              rd_clear;
  logic              status_clear;
  logic              rd_valid;
  logic [WORD_W-1:0] rd_data;
  logic [WORD_W-1:0] word;
  logic [WORD_W-1:0] exp_q[$];
  logic [WORD_W-1:0] cmp;
  logic [WORD_W-1:0] acc;
  logic [DET_W-1:0]  prev_det;
  logic              last_clr;
  int                err_count;
  int                check_count;
  int                cycles;

  // clock
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------------
  secondary_fault_status_word u_secondary_fault_status_word (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .high_side_drive_high(det[D_EXP_HIGH]), .high_side_output(det[D_HS_PIN]),
    .low_side_output(det[D_LS_PIN]), .clamp_engaged(det[D_CLAMP]),
    .secondary_regulator_fault(det[D_REG]), .secondary_rail_event(det[D_RAIL]),
    .neg_supply_over(det[D_NEG_OV]), .neg_supply_under(det[D_NEG_UV]),
    .pos_supply_over(det[D_POS_OV]), .pos_supply_under(det[D_POS_UV]),
    .regulator_current_limit(det[D_ILIM]), .ce_clamp_turnoff(det[D_CE]),
    .temp_over_threshold(det[D_TEMP+:AI_N]), .current_over_short(det[D_SC+:AI_N]),
    .current_over_limit(det[D_OC+:AI_N]), .collector_saturation_sense(det[D_SAT]),
    .neg_supply_monitor_enable(en[0]), .pos_over_monitor_disable(en[1]),
    .pos_under_monitor_disable(en[2]), .ce_clamp_enable(en[3]),
    .temp_input_enable(en[6:4]), .current_input_enable(en[9:7]),
    .status_clear(status_clear), .secondary_fault_status_three(word));

  host_reader u_host_reader (
    .ref_clk(ref_clk), .rst_n(rst_n), .rd_req(rd_req), .rd_clear(rd_clear),
    .status_word(word), .status_clear(status_clear), .rd_valid(rd_valid), .rd_data(rd_data));

  // ----------------------------------------------------------------------
  // expectation model
  // ----------------------------------------------------------------------
  // lv selects the live bits; sticky bits alone are used for stale detector values
  function automatic logic [WORD_W-1:0] exp_bits(input logic [DET_W-1:0] d, input logic [9:0] e,
                                                 input logic lv);
    logic              lvl;
    logic [WORD_W-1:0] w;
    lvl = d[D_EXP_HIGH] ? d[D_LS_PIN] : d[D_HS_PIN];
    w   = WORD_RESET;
    w[B_GATE_LEVEL]    = lv & lvl;
    w[B_CLAMP_STATE]   = lv & d[D_CLAMP];
    w[B_GATE_MISMATCH] = lvl ^ d[D_EXP_HIGH];
    w[B_REGULATOR]     = d[D_REG];
    w[B_RAIL_EVENT]    = d[D_RAIL];
    w[B_NEG_OVER]      = d[D_NEG_OV] & e[0];
    w[B_NEG_UNDER]     = d[D_NEG_UV] & e[0];
    w[B_POS_OVER]      = d[D_POS_OV] & ~e[1];
    w[B_POS_UNDER]     = d[D_POS_UV] & ~e[2];
    w[B_CE_CLAMP]      = d[D_CE] & e[3];
    w[B_OVERTEMP]      = |(d[D_TEMP+:AI_N] & e[6:4]);
    w[B_ILIMIT]        = d[D_ILIM];
    w[B_SHORT]         = |(d[D_SC+:AI_N] & e[9:7]);
    w[B_OVERCURRENT]   = |(d[D_OC+:AI_N] & e[9:7]);
    w[B_SATURATION]    = d[D_SAT];
    return w;
  endfunction : exp_bits

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  // one host read; the expected word is noted as the request goes out
  task automatic do_read(input logic [WORD_W-1:0] exp, input logic clr);
    @(negedge ref_clk);
    rd_req   = 1'b1;
    rd_clear = clr;
    exp_q.push_back(exp);
    @(negedge ref_clk);
    rd_req   = 1'b0;
    rd_clear = 1'b0;
  endtask : do_read

  // stale detector values still pass the sync stages with new enables, hence prev_det
  task automatic run_random(input int n);
    logic [WORD_W-1:0] st;
    logic              clr;
    for (int i = 0; i < n; i++) begin
      det = DET_W'($urandom & $urandom);
      en  = 10'($urandom);
      clr = 1'($urandom);
      st  = (last_clr ? WORD_RESET : acc) | exp_bits(prev_det, en, 1'b0) | exp_bits(det, en, 1'b0);
      repeat (2) @(negedge ref_clk);
      do_read(st | exp_bits(det, en, 1'b1), clr);
      acc      = st;
      last_clr = clr;
      prev_det = det;
    end
  endtask : run_random

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // monitor and watchdog
  // ----------------------------------------------------------------------
  // oldest note is compared when the host shows a result
  always @(negedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      check_count++;
      cmp = exp_q.pop_front();
      if (rd_data !== cmp) begin
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rd_data, cmp);
        err_count++;
      end
    end
  end

  // run needs well under a thousand cycles; the ceiling leaves margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    det = DET_RESET; en = '0; rd_req = 1'b0; rd_clear = 1'b0; rst_n = 1'b0;
    prev_det = DET_RESET; acc = WORD_RESET; last_clr = 1'b1;
    err_count = 0; check_count = 0; cycles = 0;
    void'($urandom(86242));
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    do_read(WORD_RESET, 1'b1);
    $display("test reset_value done");
    run_random(100);
    $display("test random_faults done");
    @(negedge ref_clk);
    rst_n = 1'b0;
    @(negedge ref_clk);
    rst_n = 1'b1;
    do_read(WORD_RESET, 1'b1);
    acc = WORD_RESET;
    last_clr = 1'b1;
    run_random(30);
    $display("test mid_reset done");
    repeat (3) @(negedge ref_clk);
    if (exp_q.size() != 0) err_count++;
    final_report();
  end
endmodule : tb
